/* File: hw/ata_port_pkg.sv */
// Package with constants and carrier types for the ATA device port block.
package ata_port_pkg;

    // Command block register indices (chip select 0).
    localparam logic [2:0] REG_DATA    = 3'h0;
    localparam logic [2:0] REG_ERROR   = 3'h1;
    localparam logic [2:0] REG_SECCNT  = 3'h2;
    localparam logic [2:0] REG_SECNUM  = 3'h3;
    localparam logic [2:0] REG_CYLLO   = 3'h4;
    localparam logic [2:0] REG_CYLHI   = 3'h5;
    localparam logic [2:0] REG_DRVHEAD = 3'h6;
    localparam logic [2:0] REG_STATUS  = 3'h7;
    // Control block register indices (chip select 1).
    localparam logic [2:0] REG_ALTSTAT = 3'h6;
    localparam logic [2:0] REG_DRVADDR = 3'h7;

    // Field positions.
    localparam int DEVCTL_IEN_N_POS = 1;
    localparam int DEVCTL_SRST_POS  = 2;
    localparam int DRVHEAD_DEV_POS  = 4;
    localparam int STAT_BUSY_POS    = 7;
    localparam int STAT_DRIVE_READY_BIT_POS    = 6;

    // Reset values and the diagnostic command code.
    localparam logic [7:0] DEVCTL_RST = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'h80;
    localparam logic [7:0] ZERO_BYTE  = 8'h00;
    localparam logic [7:0] CMD_DIAG   = 8'h90;

    // Timing: clock rate and documented times.
    localparam longint CLK_HZ        = 25000000;
    localparam longint DASP_MAX_MS   = 400;
    localparam longint DASP_WAIT_MS  = 450;
    localparam longint PDIAG_NEG_MS  = 1;
    localparam longint PDIAG_MAX_S   = 30;
    localparam longint DIAG_WAIT_S   = 6;
    // Longest times round down; all but PDIAG_NEG_CYC become parameters on the top module.
    localparam longint DASP_MAX_CYC  = CLK_HZ * DASP_MAX_MS / 1000;
    localparam longint DASP_WAIT_CYC = CLK_HZ * DASP_WAIT_MS / 1000;
    localparam longint PDIAG_NEG_CYC = CLK_HZ * PDIAG_NEG_MS / 1000;
    localparam longint PDIAG_MAX_CYC = CLK_HZ * PDIAG_MAX_S;
    localparam longint DIAG_WAIT_CYC = CLK_HZ * DIAG_WAIT_S;

    // Host bus sample carried between stages.
    typedef struct packed {
        logic       cs0_n;
        logic       cs1_n;
        logic [2:0] addr;
        logic       rd_n;
        logic       wr_n;
        logic       dmack_n;
    } host_ctl_t;

    // Presence and diagnostic handshake states.
    typedef enum logic [2:0] {
        HS_IDLE   = 3'b000,
        HS_RESET  = 3'b001,
        HS_WAIT   = 3'b010,
        HS_DIAG   = 3'b011,
        HS_DONE   = 3'b100
    } hs_state_t;

endpackage

/* File: hw/ata_device_port.sv */
// Device side of the ATA port: register decode, strobes, interrupt, DASP/PDIAG and UDMA lines.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Register accesses use data bits 7:0; data transfers use all sixteen bits.
// - With CS0, three address lines select one of eight command block registers.
// - With CS1, address lines select alternate status/device control or drive address.
// - Device captures write data on the rising edge of the write strobe.
// - Device drives addressed register while read strobe is low; host latches on rise.
// - INTRQ driven only when selected and interrupts enabled; otherwise released.
// - Pending interrupt set by processor, cleared by status read or command write.
// - IOCS16 asserted whenever the sixteen-bit data register is addressed.
// - Device 1 asserts DASP within 400 ms after reset.
// - Device 0 waits up to 450 ms for DASP; may drive it if alone.
// - Device 1 releases DASP after first valid command; then either may assert.
// - Device 1 negates PDIAG within 1 ms after reset, asserts within 30 s.
// - On diagnostics, device 1 negates PDIAG in 1 ms; device 0 waits 6 s.
// - Device 1 clears busy before asserting PDIAG.
// - Without device 1, device 0 posts own status and reports device 1 as 00h.
// - Device 0 may refuse commands until reset finishes and drive ready is set.
// - UDMA redefines strobe lines while DMACK is asserted, reverting after.
// - UDMA write: IORDY is DDMARDY, DIOR is HSTROBE; read: IORDY is DSTROBE (here IORDY copies the synchronised DIOR line).
// - UDMA data latched on both strobe edges; sender may pause strobe.
module ata_device_port
    import ata_port_pkg::*;
#(
    parameter longint DASP_MAX  = ata_port_pkg::DASP_MAX_CYC,
    parameter longint DASP_WAIT = ata_port_pkg::DASP_WAIT_CYC,
    parameter longint PDIAG_MAX = ata_port_pkg::PDIAG_MAX_CYC,
    parameter longint DIAG_WAIT = ata_port_pkg::DIAG_WAIT_CYC
) (
    // Clocks and reset.
    input  wire logic                    mclk,
    input  wire logic                    rst,
    input  wire logic                    strobe_clk,
    // Host pins.
    input  wire ata_port_pkg::host_ctl_t host_ctl,
    input  wire logic [15:0]             dd_in,
    output logic [15:0]                  dd_out,
    output logic                         dd_oe,
    output logic                         intrq_out,
    output logic                         intrq_oe,
    output logic                         iocs16_oe,
    output logic                         iordy_out,
    // Open-drain DASP and PDIAG: driving means pulling low.
    input  wire logic                    dasp_n_in,
    output logic                         dasp_oe,
    input  wire logic                    pdiag_n_in,
    output logic                         pdiag_oe,
    // Drive processor side.
    input  wire logic                    is_dev1,
    input  wire logic                    udma_mode,
    input  wire logic                    udma_read,
    input  wire logic                    irq_set,
    input  wire logic                    diag_done,
    input  wire logic                    active,
    input  wire logic [7:0]              status_in,
    input  wire logic [15:0]             rd_data,
    output logic [15:0]                  wr_data,
    output logic                         wr_pulse,
    output logic [2:0]                   wr_reg,
    output logic                         cmd_valid,
    output logic [7:0]                   cmd_code,
    output logic                         srst,
    output logic                         dev1_absent,
    output logic                         udma_word_valid,
    output logic [15:0]                  udma_word
);
    import ata_port_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, a change counts when stages two and three agree.
    host_ctl_t s1_q, s2_q, s3_q, hc_q, hc_d;
    logic [1:0] dasp_s_q, pdiag_s_q;
    logic [2:0] dasp_sy_q, pdiag_sy_q;
    logic       dasp_low_q, dasp_low_d, pdiag_low_q, pdiag_low_d;
    always_comb begin
        hc_d = (s2_q == s3_q) ? s3_q : hc_q;
        dasp_low_d  = (dasp_sy_q[1] == dasp_sy_q[2]) ? !dasp_sy_q[2] : dasp_low_q;
        pdiag_low_d = (pdiag_sy_q[1] == pdiag_sy_q[2]) ? !pdiag_sy_q[2] : pdiag_low_q;
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            s1_q <= '1; s2_q <= '1; s3_q <= '1; hc_q <= '1;
            dasp_sy_q <= '1; pdiag_sy_q <= '1;
            dasp_low_q <= 1'b0; pdiag_low_q <= 1'b0;
        end else begin
            s1_q <= host_ctl; s2_q <= s1_q; s3_q <= s2_q; hc_q <= hc_d;
            dasp_sy_q <= {dasp_sy_q[1:0], dasp_n_in};
            pdiag_sy_q <= {pdiag_sy_q[1:0], pdiag_n_in};
            dasp_low_q <= dasp_low_d; pdiag_low_q <= pdiag_low_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register decode, strobes and interrupt.
    logic       prev_wr_q, prev_rd_q, udma_q;
    logic [7:0] devctl_q, devctl_d, drvhead_q, drvhead_d;
    logic       irq_q, irq_d, ready_q, ready_d;
    logic       sel_cmd, sel_ctl, wr_rise, rd_fall, udma_on, selected;
    logic [15:0] dd_d;
    logic       dd_oe_d, io16_d, wp_d, cv_d;
    assign sel_cmd  = !hc_q.cs0_n && hc_q.cs1_n;
    assign sel_ctl  = hc_q.cs0_n && !hc_q.cs1_n;
    assign udma_on  = udma_mode && !hc_q.dmack_n;
    assign wr_rise  = !prev_wr_q && hc_q.wr_n && !udma_q;
    assign rd_fall  = prev_rd_q && !hc_q.rd_n && !udma_q;
    assign selected = drvhead_q[DRVHEAD_DEV_POS] == is_dev1;
    always_comb begin
        devctl_d  = devctl_q;
        drvhead_d = drvhead_q;
        irq_d     = irq_q;
        ready_d   = ready_q || (diag_done && !is_dev1);
        wp_d      = 1'b0;
        cv_d      = 1'b0;
        if (wr_rise && sel_ctl && hc_q.addr == REG_ALTSTAT) begin
            devctl_d = dd_in[7:0];
        end
        if (wr_rise && sel_cmd) begin
            wp_d = 1'b1;
            if (hc_q.addr == REG_DRVHEAD) drvhead_d = dd_in[7:0];
            // Commands are dropped for device 0 until it reports ready.
            if (hc_q.addr == REG_STATUS && selected && (ready_q || is_dev1)) begin
                cv_d  = 1'b1;
                irq_d = 1'b0;
            end
        end
        if (rd_fall && sel_cmd && hc_q.addr == REG_STATUS && selected) irq_d = 1'b0;
        if (irq_set) irq_d = 1'b1;
        // Reads: data register is sixteen bits, others use the low byte.
        dd_oe_d = !hc_q.rd_n && (sel_cmd || sel_ctl) && selected && !udma_q;
        dd_d    = rd_data;
        if (!(sel_cmd && hc_q.addr == REG_DATA)) dd_d = {ZERO_BYTE, rd_data[7:0]};
        if (sel_cmd && hc_q.addr == REG_STATUS || sel_ctl && hc_q.addr == REG_ALTSTAT) begin
            dd_d = {ZERO_BYTE, status_in};
        end
        io16_d = sel_cmd && hc_q.addr == REG_DATA && selected;
    end
    always_ff @(posedge mclk) begin
        if (rst || devctl_q[DEVCTL_SRST_POS]) begin
            prev_wr_q <= 1'b1; prev_rd_q <= 1'b1; udma_q <= 1'b0;
            devctl_q <= rst ? DEVCTL_RST : devctl_d;
            drvhead_q <= ZERO_BYTE; irq_q <= 1'b0; ready_q <= 1'b0;
            dd_out <= '0; dd_oe <= 1'b0; iocs16_oe <= 1'b0;
            wr_data <= '0; wr_pulse <= 1'b0; wr_reg <= '0;
            cmd_valid <= 1'b0; cmd_code <= ZERO_BYTE;
            intrq_out <= 1'b0; intrq_oe <= 1'b0;
        end else begin
            prev_wr_q <= hc_q.wr_n; prev_rd_q <= hc_q.rd_n; udma_q <= udma_on;
            devctl_q <= devctl_d; drvhead_q <= drvhead_d;
            irq_q <= irq_d; ready_q <= ready_d;
            dd_out <= dd_d; dd_oe <= dd_oe_d; iocs16_oe <= io16_d;
            wr_data <= dd_in; wr_pulse <= wp_d; wr_reg <= hc_q.addr;
            cmd_valid <= cv_d; cmd_code <= dd_in[7:0];
            intrq_out <= irq_q;
            intrq_oe <= selected && !devctl_q[DEVCTL_IEN_N_POS];
        end
    end
    assign srst = devctl_q[DEVCTL_SRST_POS];

    a_intrq_gate: assert property (@(posedge mclk) disable iff (rst)
        devctl_q[DEVCTL_IEN_N_POS] |=> !intrq_oe)
        else $error("INTRQ driven while interrupts disabled");
    a_irq_clear: assert property (@(posedge mclk) disable iff (rst)
        cv_d && !irq_set && !devctl_q[DEVCTL_SRST_POS] |=> !irq_q)
        else $error("Pending interrupt not cleared by command");
    a_iocs16_data: assert property (@(posedge mclk) disable iff (rst)
        !devctl_q[DEVCTL_SRST_POS] && sel_cmd && hc_q.addr == REG_DATA && selected
        |=> iocs16_oe)
        else $error("IOCS16 missing on data register");
    a_write_edge: assert property (@(posedge mclk) disable iff (rst)
        wr_pulse |-> $past(hc_q.wr_n) && !$past(prev_wr_q))
        else $error("Write taken without rising strobe");
    a_read_drive: assert property (@(posedge mclk) disable iff (rst)
        dd_oe |-> $past(!hc_q.rd_n))
        else $error("Data driven without read strobe");
    a_cmd_ready: assert property (@(posedge mclk) disable iff (rst)
        cmd_valid && !is_dev1 |-> $past(ready_q))
        else $error("Device 0 accepted command before ready");

    ////////////////////////////////////////////////////////////////////////////
    // DASP / PDIAG presence and diagnostic handshake.
    hs_state_t  hs_q, hs_d;
    logic [31:0] cnt_q, cnt_d;
    logic       first_cmd_q, first_cmd_d, dev1_seen_q, dev1_seen_d;
    logic       dasp_d, pdiag_d, absent_d;
    logic       rst_seen_q;
    always_comb begin
        hs_d = hs_q;
        cnt_d = cnt_q + 32'h0000_0001;
        first_cmd_d = first_cmd_q || (cmd_valid && is_dev1);
        dev1_seen_d = dev1_seen_q;
        absent_d = dev1_absent;
        dasp_d = 1'b0;
        pdiag_d = 1'b0;
        unique case (hs_q)
            HS_RESET: begin
                cnt_d = '0;
                hs_d = HS_WAIT;
            end
            HS_WAIT: begin
                if (is_dev1) begin
                    dasp_d = !first_cmd_q;
                    // Assert only once busy has cleared and diagnostics passed.
                    if (diag_done && !status_in[STAT_BUSY_POS] &&
                        cnt_q < 32'(PDIAG_MAX)) begin
                        hs_d = HS_DONE;
                    end
                end else begin
                    if (dasp_low_q) dev1_seen_d = 1'b1;
                    if (cnt_q >= 32'(DASP_WAIT)) hs_d = HS_DIAG;
                end
            end
            HS_DIAG: begin
                // Device 0 waits for device 1 to report, or posts its own status.
                if (!dev1_seen_q || pdiag_low_q || cnt_q >= 32'(DIAG_WAIT)) begin
                    absent_d = !dev1_seen_q;
                    hs_d = HS_DONE;
                end
            end
            HS_DONE: begin
                pdiag_d = is_dev1;
                dasp_d = is_dev1 ? (!first_cmd_q || active) : (active && !dasp_low_q);
                if (cmd_valid && cmd_code == CMD_DIAG) begin
                    cnt_d = '0;
                    hs_d = is_dev1 ? HS_WAIT : HS_DIAG;
                end
            end
            HS_IDLE: hs_d = HS_RESET;
        endcase
        if (devctl_q[DEVCTL_SRST_POS]) hs_d = HS_RESET;
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            hs_q <= HS_IDLE; cnt_q <= '0; first_cmd_q <= 1'b0; dev1_seen_q <= 1'b0;
            dasp_oe <= 1'b0; pdiag_oe <= 1'b0; dev1_absent <= 1'b0; rst_seen_q <= 1'b0;
        end else begin
            hs_q <= hs_d; cnt_q <= cnt_d; first_cmd_q <= first_cmd_d;
            dev1_seen_q <= dev1_seen_d; rst_seen_q <= 1'b1;
            dasp_oe <= dasp_d; pdiag_oe <= pdiag_d; dev1_absent <= absent_d;
        end
    end
    a_pdiag_neg: assert property (@(posedge mclk) disable iff (rst)
        hs_q == HS_RESET |=> ##1 !pdiag_oe)
        else $error("PDIAG not negated after reset");
    a_dasp_dev1: assert property (@(posedge mclk) disable iff (rst)
        hs_q == HS_WAIT && is_dev1 && !first_cmd_q |=> dasp_oe)
        else $error("Device 1 did not assert DASP");

    ////////////////////////////////////////////////////////////////////////////
    // UDMA: data out latched on both HSTROBE edges in the strobe domain.
    logic [15:0] rise_w_q, fall_w_q;
    logic        rise_t_q, fall_t_q;
    logic [2:0]  rt_s_q, ft_s_q;
    // The strobe only runs inside bursts, so the toggles need a reset that does not wait for it.
    always_ff @(posedge strobe_clk or posedge rst) begin
        if (rst) begin
            rise_w_q <= '0;
            rise_t_q <= 1'b0;
        end else begin
            rise_w_q <= dd_in;
            rise_t_q <= !rise_t_q;
        end
    end
    always_ff @(negedge strobe_clk or posedge rst) begin
        if (rst) begin
            fall_w_q <= '0;
            fall_t_q <= 1'b0;
        end else begin
            fall_w_q <= dd_in;
            fall_t_q <= !fall_t_q;
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            rt_s_q <= '0; ft_s_q <= '0;
            udma_word_valid <= 1'b0; udma_word <= '0; iordy_out <= 1'b1;
        end else begin
            rt_s_q <= {rt_s_q[1:0], rise_t_q};
            ft_s_q <= {ft_s_q[1:0], fall_t_q};
            udma_word_valid <= udma_q && !udma_read &&
                               (rt_s_q[2] != rt_s_q[1] || ft_s_q[2] != ft_s_q[1]);
            udma_word <= (rt_s_q[2] != rt_s_q[1]) ? rise_w_q : fall_w_q;
            // Write: IORDY is device ready; read: it follows the synchronised DIOR (hc_q.rd_n) line.
            iordy_out <= udma_q ? (udma_read ? hc_q.rd_n : 1'b0) : 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: verif/peer_drive_model.sv */
// Behavioural model of the second drive sharing the cable: presence and diagnostic lines.
`timescale 1ns/100ps
`default_nettype none
module peer_drive_model #(
    parameter int ON_DLY   = 30,
    parameter int DIAG_DLY = 60
) (
    // Clock and reset.
    input  wire logic mclk,
    input  wire logic rst,
    // Whether a second drive is fitted at all.
    input  wire logic present,
    // Open-drain pulls: high means the line is pulled low.
    output logic      dasp_pull,
    output logic      pdiag_pull
);
    int cnt;
    ////////////////////////////////////////////////////////////////////////////////
    // Counting from reset release keeps the model as slow as a real drive may be.
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt <= 0;
        end else if (cnt < 1000) begin
            cnt <= cnt + 1;
        end
    end
    assign dasp_pull  = present && !rst && cnt >= ON_DLY;
    assign pdiag_pull = present && !rst && cnt >= DIAG_DLY;
endmodule
`default_nettype wire

/* File: verif/ata_device_port_tb.sv */
// Self-checking testbench for the ATA device port block.
`timescale 1ns/100ps
`default_nettype none
module ata_device_port_tb;
    import ata_port_pkg::*;
    localparam longint DW = 100;
    logic        mclk = 0, rst = 1, strobe_clk = 0, present = 0;
    host_ctl_t   hc;
    logic [15:0] dd_in, dd_out, rd_data, wr_data, udma_word;
    logic [7:0]  status_in, cmd_code;
    logic [2:0]  wr_reg;
    logic        dd_oe, intrq_out, intrq_oe, iocs16_oe, iordy_out, dasp_oe, pdiag_oe;
    logic        is_dev1, udma_mode, irq_set, diag_done, wr_pulse, cmd_valid, srst;
    logic        dev1_absent, udma_word_valid, p_dasp, p_pdiag;
    logic [18:0] wq[$];
    logic [7:0]  cq[$];
    logic [15:0] uq[$];
    logic [18:0] we;
    int          error_cnt = 0, tests_run = 0, cyc = 0;
    ata_device_port #(.DASP_MAX(50), .DASP_WAIT(DW), .PDIAG_MAX(200), .DIAG_WAIT(150))
    ata_device_port_i (.mclk(mclk), .rst(rst), .strobe_clk(strobe_clk), .host_ctl(hc),
        .dd_in(dd_in), .dd_out(dd_out), .dd_oe(dd_oe), .intrq_out(intrq_out),
        .intrq_oe(intrq_oe), .iocs16_oe(iocs16_oe), .iordy_out(iordy_out),
        .dasp_n_in(!(dasp_oe || p_dasp)), .dasp_oe(dasp_oe),
        .pdiag_n_in(!(pdiag_oe || p_pdiag)), .pdiag_oe(pdiag_oe), .is_dev1(is_dev1),
        .udma_mode(udma_mode), .udma_read(1'b0), .irq_set(irq_set), .diag_done(diag_done),
        .active(1'b0), .status_in(status_in), .rd_data(rd_data), .wr_data(wr_data),
        .wr_pulse(wr_pulse), .wr_reg(wr_reg), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .srst(srst), .dev1_absent(dev1_absent), .udma_word_valid(udma_word_valid),
        .udma_word(udma_word));
    peer_drive_model peer_drive_model_i (.mclk(mclk), .rst(rst), .present(present),
        .dasp_pull(p_dasp), .pdiag_pull(p_pdiag));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #20 mclk = ~mclk;
    end
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // The host holds reset low through power-up; here rst models that level.
    task automatic do_reset();
        @(negedge mclk);
        rst = 1;
        repeat (20) @(negedge mclk);
        rst = 0;
        repeat (6) @(negedge mclk);
    endtask
    // One PIO cycle; strobe phases are held well past the sync latency.
    task automatic acc(input logic c1, input logic [2:0] a, input logic wr,
                       input logic [15:0] d, input logic [15:0] e);
        logic [15:0] m;
        m = (!c1 && a == REG_DATA) ? 16'hFFFF : 16'h00FF;
        @(negedge mclk);
        hc.cs0_n = c1;
        hc.cs1_n = !c1;
        hc.addr = a;
        dd_in = d;
        repeat (2) @(negedge mclk);
        if (wr) hc.wr_n = 0;
        else hc.rd_n = 0;
        repeat (8) @(negedge mclk);
        if (!c1) chk(iocs16_oe, a == REG_DATA);
        if (!wr) begin
            chk(dd_oe, 1'b1);
            chk(dd_out & m, e & m);
        end
        hc.wr_n = 1;
        hc.rd_n = 1;
        repeat (8) @(negedge mclk);
        hc.cs0_n = 1;
        hc.cs1_n = 1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Result watcher: every pulse from the design, except a wr_pulse for REG_STATUS, consumes the oldest note.
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            complete_run();
        end
        if (!rst && wr_pulse === 1'b1 && wr_reg !== REG_STATUS) begin
            if (wq.size() == 0) chk(16'h1, 16'h0);
            else begin
                we = wq.pop_front();
                chk({13'h0, wr_reg}, {13'h0, we[18:16]});
                chk(wr_data & (we[18:16] == 0 ? 16'hFFFF : 16'h00FF), we[15:0]);
            end
        end
        if (!rst && cmd_valid === 1'b1) begin
            if (cq.size() == 0) chk(16'h2, 16'h0);
            else chk({8'h0, cmd_code}, {8'h0, cq.pop_front()});
        end
        if (!rst && udma_word_valid === 1'b1) begin
            if (uq.size() == 0) chk(16'h3, 16'h0);
            else chk(udma_word, uq.pop_front());
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [15:0] d;
        hc = '{cs0_n: 1, cs1_n: 1, addr: 3'h0, rd_n: 1, wr_n: 1, dmack_n: 1};
        {dd_in, rd_data, status_in, is_dev1, udma_mode, irq_set, diag_done} = '0;
        void'($urandom(60));
        do_reset();
        chk({dd_oe, intrq_oe, iordy_out}, 3'b011);
        repeat (DW + 20) @(negedge mclk);
        chk(dev1_absent, 1'b1);
        for (int a = 0; a < 7; a++) begin
            d = $urandom;
            if (a == REG_DRVHEAD) d[DRVHEAD_DEV_POS] = 1'b0;
            wq.push_back({a[2:0], d & (a == 0 ? 16'hFFFF : 16'h00FF)});
            acc(0, a[2:0], 1, d, 16'h0);
        end
        rd_data = $urandom;
        status_in = $urandom;
        acc(0, REG_DATA, 0, 16'h0, rd_data);
        acc(1, REG_ALTSTAT, 0, 16'h0, {8'h0, status_in});
        acc(1, REG_ALTSTAT, 1, 16'h0000, 16'h0);
        @(negedge mclk) irq_set = 1;
        @(negedge mclk) irq_set = 0;
        repeat (4) @(negedge mclk);
        chk({intrq_oe, intrq_out}, 2'b11);
        acc(0, REG_STATUS, 0, 16'h0, {8'h0, status_in});
        chk({intrq_oe, intrq_out}, 2'b10);
        acc(1, REG_ALTSTAT, 1, 16'h0002, 16'h0);
        chk(intrq_oe, 1'b0);
        acc(0, REG_STATUS, 1, {8'h0, CMD_DIAG}, 16'h0);
        diag_done = 1;
        cq.push_back(CMD_DIAG);
        acc(0, REG_STATUS, 1, {8'h0, CMD_DIAG}, 16'h0);
        present = 1;
        do_reset();
        repeat (DW + 20) @(negedge mclk);
        chk(dev1_absent, 1'b0);
        present = 0;
        is_dev1 = 1;
        diag_done = 0;
        do_reset();
        chk(pdiag_oe, 1'b0);
        repeat (50) @(negedge mclk);
        chk(dasp_oe, 1'b1);
        status_in[STAT_BUSY_POS] = 1'b0;
        diag_done = 1;
        repeat (10) @(negedge mclk);
        chk(pdiag_oe, 1'b1);
        udma_mode = 1;
        hc.dmack_n = 0;
        repeat (8) @(negedge mclk);
        chk(iordy_out, 1'b0);
        // Each strobe edge is left alone until its word has crossed into the system clock.
        for (int i = 0; i < 6; i++) begin
            dd_in = $urandom;
            uq.push_back(dd_in);
            #12 strobe_clk = ~strobe_clk;
            repeat (6) @(negedge mclk);
        end
        repeat (12) @(negedge mclk);
        hc.dmack_n = 1;
        repeat (12) @(negedge mclk);
        chk(wq.size() + cq.size() + uq.size(), 16'h0);
        complete_run();
    end
endmodule
`default_nettype wire
